// ### inc/dccr_pkg.sv
`default_nettype none
package dccr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] PAGE_CMP0 = 8'h01;
  localparam logic [7:0] PAGE_CMP1 = 8'h02;
  localparam logic [7:0] PAGE_CMP0_MODE = 8'h01;
  localparam logic [7:0] PAGE_CMP1_MODE = 8'h02;

  // ----------------------------------------
  // Control register field positions
  // ----------------------------------------
  localparam int CTL_ON = 7;
  localparam int CTL_RESULT = 6;
  localparam int CTL_RISE = 5;
  localparam int CTL_FALL = 4;
  localparam int CTL_POS_HI = 3;
  localparam int CTL_POS_LO = 2;
  localparam int CTL_NEG_HI = 1;
  localparam int CTL_NEG_LO = 0;

  // ----------------------------------------
  // Mode register field positions
  // ----------------------------------------
  localparam int MD_RISE_IE = 5;
  localparam int MD_FALL_IE = 4;
  localparam int MD_SPEED_HI = 1;
  localparam int MD_SPEED_LO = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] SPEED_RESET = 2'h2;
  localparam logic [1:0] HYST_RESET = 2'h0;

  // Response speed selections
  typedef enum logic [1:0] {
    DCCR_SPEED_FAST = 2'b00,
    DCCR_SPEED_MID1 = 2'b01,
    DCCR_SPEED_MID2 = 2'b10,
    DCCR_SPEED_LOW_POWER = 2'b11
  } dccr_speed_t;

  // Per-comparator settings driven to the analog macro
  typedef struct packed {
    logic on;
    logic [1:0] pos_hyst;
    logic [1:0] neg_hyst;
    logic [1:0] speed_sel;
  } dccr_analog_t;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dccr_req_t;

endpackage
`default_nettype wire

// ### design/dccr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dccr_sync (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic async_in, // Raw comparator output
  output logic sync_out // Synchronised level
);

  logic stage1;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// ### design/dccr_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dccr_channel (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic raw_out, // Analog comparator output pin
  input wire logic ctl_wr, // Control register write strobe
  input wire logic md_wr, // Mode register write strobe
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] ctl_rd, // Control register read value
  output logic [7:0] md_rd, // Mode register read value
  output dccr_pkg::dccr_analog_t analog, // Settings for the analog macro
  output logic routed_out, // Output toward the pin router
  output logic irq // Interrupt request
);

  logic on;
  logic rise_flag;
  logic fall_flag;
  logic [1:0] pos_hyst;
  logic [1:0] neg_hyst;
  logic rise_irq_en;
  logic fall_irq_en;
  logic [1:0] speed_sel;
  logic result;
  logic result_d;
  logic rise_evt;
  logic fall_evt;

  // ----------------------------------------
  // Output synchronisation and edge detect
  // ----------------------------------------
  dccr_sync u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(raw_out),
    .sync_out(result)
  );

  // Previous synchronised value
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      result_d <= 1'b0;
    end else begin
      result_d <= result;
    end
  end

  assign rise_evt = result & ~result_d;
  assign fall_evt = ~result & result_d;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      on <= dccr_pkg::CONTROL_RESET[dccr_pkg::CTL_ON];
      pos_hyst <= dccr_pkg::HYST_RESET;
      neg_hyst <= dccr_pkg::HYST_RESET;
    end else if (ctl_wr) begin
      on <= wdata[dccr_pkg::CTL_ON];
      pos_hyst <= wdata[dccr_pkg::CTL_POS_HI:dccr_pkg::CTL_POS_LO];
      neg_hyst <= wdata[dccr_pkg::CTL_NEG_HI:dccr_pkg::CTL_NEG_LO];
    end
  end

  // Sticky edge flags, event wins over software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rise_flag <= dccr_pkg::CONTROL_RESET[dccr_pkg::CTL_RISE];
      fall_flag <= dccr_pkg::CONTROL_RESET[dccr_pkg::CTL_FALL];
    end else begin
      if (rise_evt) begin
        rise_flag <= 1'b1;
      end else if (ctl_wr) begin
        rise_flag <= wdata[dccr_pkg::CTL_RISE];
      end
      if (fall_evt) begin
        fall_flag <= 1'b1;
      end else if (ctl_wr) begin
        fall_flag <= wdata[dccr_pkg::CTL_FALL];
      end
    end
  end

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rise_irq_en <= 1'b0;
      fall_irq_en <= 1'b0;
      speed_sel <= dccr_pkg::SPEED_RESET;
    end else if (md_wr) begin
      rise_irq_en <= wdata[dccr_pkg::MD_RISE_IE];
      fall_irq_en <= wdata[dccr_pkg::MD_FALL_IE];
      speed_sel <= wdata[dccr_pkg::MD_SPEED_HI:dccr_pkg::MD_SPEED_LO];
    end
  end

  // ----------------------------------------
  // Read values and outputs
  // ----------------------------------------
  assign ctl_rd = {on, result, rise_flag, fall_flag, pos_hyst, neg_hyst};
  assign md_rd = {2'b00, rise_irq_en, fall_irq_en, 2'b00, speed_sel};
  assign analog = '{on: on, pos_hyst: pos_hyst, neg_hyst: neg_hyst, speed_sel: speed_sel};
  assign routed_out = on & result;

  // Request held while the comparator is on and a flag and its enable are both set
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= on & ((rise_flag & rise_irq_en) | (fall_flag & fall_irq_en));
    end
  end

endmodule
`default_nettype wire

// ### design/dccr_top.sv
// Behaviour
// - Control bit 7 written 1 enables the comparator, written 0 disables it.
// - Control bit 6 shows the current comparator result.
// - Control bit 5 sets on a rising output edge.
// - Control bit 4 sets on a falling output edge.
// - Control bits 3:2 select positive hysteresis: off, 5, 10, 15 mV.
// - Control bits 1:0 select negative hysteresis: off, 5, 10, 15 mV.
// - Mode bit 5 enables rising-edge interrupt requests.
// - Mode bit 4 enables falling-edge interrupt requests.
// - Mode bits 1:0 pick response speed, 0 fastest, 3 lowest power.
// - Unused mode bits 7:6 and 3:2 read zero, writes ignored.
// - Reset clears every control register bit.
// - Control at 0x88, mode at 0x89; page picks the comparator.
// - Edge flags stay set until software writes them zero.
// - Disabled comparator drives routed output low and raises no interrupt.
`timescale 1ns/1ps
`default_nettype none
module dccr_top (
  input wire logic ref_clk, // System clock, 50 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire dccr_pkg::dccr_req_t req, // Register access request
  output logic [7:0] rdata, // Read data, registered
  input wire logic cmp0_raw, // Comparator 0 analog output
  input wire logic cmp1_raw, // Comparator 1 analog output
  output dccr_pkg::dccr_analog_t cmp0_analog, // Comparator 0 settings
  output dccr_pkg::dccr_analog_t cmp1_analog, // Comparator 1 settings
  output logic cmp0_routed, // Comparator 0 output to router
  output logic cmp1_routed, // Comparator 1 output to router
  output logic cmp0_irq, // Comparator 0 interrupt request
  output logic cmp1_irq // Comparator 1 interrupt request
);

  logic [1:0] ctl_wr;
  logic [1:0] md_wr;
  logic [7:0] ctl_rd [2];
  logic [7:0] md_rd [2];
  logic [7:0] next_rdata;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] p,
                               input logic [7:0] ea, input logic [7:0] ep);
    hit = (a == ea) && (p == ep);
  endfunction

  // Write strobes per comparator
  assign ctl_wr[0] = req.wr & hit(req.addr, req.page, dccr_pkg::ADDR_CONTROL,
                                  dccr_pkg::PAGE_CMP0);
  assign ctl_wr[1] = req.wr & hit(req.addr, req.page, dccr_pkg::ADDR_CONTROL,
                                  dccr_pkg::PAGE_CMP1);
  assign md_wr[0] = req.wr & hit(req.addr, req.page, dccr_pkg::ADDR_MODE,
                                 dccr_pkg::PAGE_CMP0_MODE);
  assign md_wr[1] = req.wr & hit(req.addr, req.page, dccr_pkg::ADDR_MODE,
                                 dccr_pkg::PAGE_CMP1_MODE);

  // ----------------------------------------
  // Comparator channels
  // ----------------------------------------
  dccr_channel u_ch0 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw_out(cmp0_raw),
    .ctl_wr(ctl_wr[0]),
    .md_wr(md_wr[0]),
    .wdata(req.wdata),
    .ctl_rd(ctl_rd[0]),
    .md_rd(md_rd[0]),
    .analog(cmp0_analog),
    .routed_out(cmp0_routed),
    .irq(cmp0_irq)
  );

  dccr_channel u_ch1 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw_out(cmp1_raw),
    .ctl_wr(ctl_wr[1]),
    .md_wr(md_wr[1]),
    .wdata(req.wdata),
    .ctl_rd(ctl_rd[1]),
    .md_rd(md_rd[1]),
    .analog(cmp1_analog),
    .routed_out(cmp1_routed),
    .irq(cmp1_irq)
  );

  // ----------------------------------------
  // Read multiplexer, unmapped reads return zero
  // ----------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (hit(req.addr, req.page, dccr_pkg::ADDR_CONTROL, dccr_pkg::PAGE_CMP0)) begin
      next_rdata = ctl_rd[0];
    end else if (hit(req.addr, req.page, dccr_pkg::ADDR_CONTROL, dccr_pkg::PAGE_CMP1)) begin
      next_rdata = ctl_rd[1];
    end else if (hit(req.addr, req.page, dccr_pkg::ADDR_MODE, dccr_pkg::PAGE_CMP0_MODE)) begin
      next_rdata = md_rd[0];
    end else if (hit(req.addr, req.page, dccr_pkg::ADDR_MODE, dccr_pkg::PAGE_CMP1_MODE)) begin
      next_rdata = md_rd[1];
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ### tb/dccr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dccr_chk (
  input wire logic ref_clk, // Clock
  input wire logic rst_b, // Reset
  input wire dccr_pkg::dccr_req_t req, // Access
  input wire logic [7:0] rdata, // Read data
  input wire logic cmp0_raw, // Output 0
  input wire dccr_pkg::dccr_analog_t cmp0_analog, // Settings 0
  input wire dccr_pkg::dccr_analog_t cmp1_analog, // Settings 1
  input wire logic cmp0_routed, // Routed 0
  input wire logic cmp0_irq, // Irq 0
  input wire logic cmp1_irq // Irq 1
);
  // ------
  // Checks
  // ------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic wr0;
  logic ctl0_wr;
  // Page 1 writes
  assign wr0 = req.wr && req.page == 8'h01;
  assign ctl0_wr = wr0 && req.addr == 8'h88;
  chk_write_on: assert property (ctl0_wr |=> cmp0_analog.on == $past(req.wdata[7]))
    else $error("enable bit not taken");
  chk_write_hyst: assert property (
    ctl0_wr |=> {cmp0_analog.pos_hyst, cmp0_analog.neg_hyst} == $past(req.wdata[3:0]))
    else $error("hysteresis not taken");
  chk_mode_speed: assert property (
    req.wr && req.page == 8'h02 && req.addr == 8'h89
    |=> cmp1_analog.speed_sel == $past(req.wdata[1:0]))
    else $error("speed not taken");
  chk_unused_zero: assert property (
    req.rd && req.addr == 8'h89 |=> rdata[7:6] == 2'b00 && rdata[3:2] == 2'b00)
    else $error("unused mode bits set");
  chk_reset_clear: assert property (disable iff (1'b0)
    !rst_b |=> cmp0_analog == 7'h02 && cmp1_analog == 7'h02 && !cmp0_irq && !cmp0_routed
    && !cmp1_irq && rdata == 8'h00)
    else $error("reset values wrong");
  chk_routed_off: assert property (!cmp0_analog.on |-> !cmp0_routed)
    else $error("routed high while off");
  chk_irq_off: assert property ((!cmp1_analog.on)[*2] |-> !cmp1_irq)
    else $error("irq while off");
  chk_routed_follow: assert property (
    (cmp0_analog.on && cmp0_raw)[*4] |-> cmp0_routed)
    else $error("result not routed");
  chk_irq_hold: assert property (cmp0_irq && !wr0 && !$past(wr0) |=> cmp0_irq)
    else $error("irq dropped");
  cov_irq0: cover property (cmp0_irq);
  cov_irq1: cover property ($rose(cmp1_irq));
  cov_unmapped: cover property (req.rd && req.page == 8'h03);
endmodule
bind dccr_top dccr_chk i_dccr_chk (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
  .rdata(rdata), .cmp0_raw(cmp0_raw), .cmp0_analog(cmp0_analog), .cmp1_analog(cmp1_analog),
  .cmp0_routed(cmp0_routed), .cmp0_irq(cmp0_irq), .cmp1_irq(cmp1_irq));
`default_nettype wire

// ### tb/dccr_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
module dccr_cmp_model (
  input wire logic [1:0] above, // Plus above minus
  input wire dccr_pkg::dccr_analog_t analog0, // Settings 0
  input wire dccr_pkg::dccr_analog_t analog1, // Settings 1
  output logic raw0, // Output 0
  output logic raw1 // Output 1
);
  // Shut-down comparator rests low, settles off the clock edge
  assign #3 raw0 = analog0.on & above[0];
  assign #3 raw1 = analog1.on & above[1];
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  dccr_pkg::dccr_req_t req = '0;
  dccr_pkg::dccr_analog_t a0, a1;
  logic [7:0] rdata, d, m, got;
  logic [1:0] above = 2'b00;
  wire [1:0] r, o, q;
  int bad_count = 0;
  int compares = 0;
  integer seed = 32'h8046_508a;
  int ch;
  // ------
  // Set-up
  // ------
  always #10 ref_clk = ~ref_clk;
  dccr_top i_dccr_top (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .cmp0_raw(r[0]), .cmp1_raw(r[1]), .cmp0_analog(a0), .cmp1_analog(a1),
    .cmp0_routed(o[0]), .cmp1_routed(o[1]), .cmp0_irq(q[0]), .cmp1_irq(q[1]));
  dccr_cmp_model i_model (.above(above), .analog0(a0), .analog1(a1), .raw0(r[0]), .raw1(r[1]));
  // Expected control read
  function automatic logic [7:0] ctl_exp(input logic [7:0] v, input logic res);
    return {v[7], res, v[5:0]};
  endfunction
  // Compare and count
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One register access, page ch plus one
  task automatic access(input logic w, input int c, input logic [7:0] ad, input logic [7:0] v);
    req <= '{wr: w, rd: !w, page: 8'(c + 1), addr: ad, wdata: v};
    @(posedge ref_clk);
    req <= '0;
    @(posedge ref_clk);
    got = rdata;
  endtask
  // Verdict
  task automatic complete_run;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Run limit
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    $display("[FAIL] %0t run limit", $time);
    complete_run;
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Writes to an unmapped page must land nowhere
    access(1, 2, 8'h88, 8'hff);
    access(1, 2, 8'h89, 8'hff);
    for (ch = 0; ch < 3; ch++) begin
      access(0, ch, 8'h88, 8'h00);
      check(got, 8'h00);
      access(0, ch, 8'h89, 8'h00);
      check(got, ch < 2 ? 8'h02 : 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      ch = i % 2;
      d = i < 8 ? 8'h80 | 8'(i / 2 * 5) : 8'($random(seed));
      m = i < 8 ? 8'hcc | 8'(i / 2) : 8'($random(seed));
      access(1, ch, 8'h88, d);
      access(1, ch, 8'h89, m);
      check({1'b0, (ch ? a1 : a0)}, {1'b0, d[7], d[3:0], m[1:0]});
      access(0, ch, 8'h88, 8'h00);
      check(got, ctl_exp(d, 1'b0));
      access(0, ch, 8'h89, 8'h00);
      check(got, m & 8'h33);
    end
    for (ch = 0; ch < 2; ch++) begin
      access(1, ch, 8'h89, 8'h00);
      access(1, ch, 8'h88, 8'h80);
      above[ch] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      access(1, ch, 8'h88, 8'h80);
      access(1, ch, 8'h89, 8'h20);
      above[ch] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check({6'h0, o[ch], q[ch]}, 8'h00);
      above[ch] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check({6'h0, o[ch], q[ch]}, 8'h03);
      access(0, ch, 8'h88, 8'h00);
      check(got, 8'hf0);
      access(1, ch, 8'h88, 8'h80);
      access(1, ch, 8'h89, 8'h10);
      check({6'h0, o[ch], q[ch]}, 8'h02);
      access(1, ch, 8'h88, 8'h10);
      repeat (6) @(posedge ref_clk);
      check({6'h0, o[ch], q[ch]}, 8'h00);
      access(0, ch, 8'h88, 8'h00);
      check(got, 8'h10);
      access(1, ch, 8'h88, 8'h90);
      repeat (6) @(posedge ref_clk);
      check({6'h0, o[ch], q[ch]}, 8'h03);
    end
    // Reset again in mid-run, then read back the reset values
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (ch = 0; ch < 2; ch++) begin
      access(0, ch, 8'h88, 8'h00);
      check(got, 8'h00);
      access(0, ch, 8'h89, 8'h00);
      check(got, 8'h02);
    end
    complete_run;
  end
endmodule
`default_nettype wire
